/* ledfc_timer.sv */
// shared constants of the led fault block and its hold timer
`timescale 1ns/100ps
`default_nettype none

package ledfc_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned TMR_W        = 18;
  localparam int unsigned STALL_US     = 100;
  localparam int unsigned STARTUP_US   = 100;
  localparam int unsigned STANDBY_MS   = 15;
  // least times round up to whole cycles
  localparam int unsigned STALL_CYC    = (STALL_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned STARTUP_CYC  = (STARTUP_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned STANDBY_CYC  = (STANDBY_MS * CLK_HZ + 999) / 1_000;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATE     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h10;
  // control fields and reset values
  localparam int unsigned CTRL_BLANK_BIT = 0;
  localparam logic        CTRL_BLANK_RST = 1'b0;
  // interrupt layout
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned IRQ_FAULT    = 0;
  localparam int unsigned IRQ_STANDBY  = 1;
  localparam int unsigned IRQ_READY    = 2;
  localparam int unsigned IRQ_STALL    = 3;
  localparam logic [3:0]  IRQ_EN_RST   = 4'h0;
  // state word fields
  localparam int unsigned ST_LVL_LSB   = 0;
  localparam int unsigned ST_FSM_LSB   = 4;
  localparam int unsigned ST_FLAG_BIT  = 6;
  localparam int unsigned ST_VALID_BIT = 7;
  // number of pin inputs that pass the synchroniser
  localparam int unsigned SYNC_W       = 10;

  typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_STANDBY} ledfc_state_type;
  typedef enum logic [2:0] {LVL_NORMAL, LVL_SEV2_UV, LVL_SEV2, LVL_SEV3, LVL_SEV4,
                            LVL_ZERO} ledfc_level_type;
endpackage

// saturating up-counter, done once it reaches its limit
module ledfc_timer import ledfc_pkg::*; (
  input  wire logic             clk_i,   // system clock
  input  wire logic             rst_i,   // sync reset, high
  input  wire logic             clear_i, // restart from zero
  input  wire logic             en_i,    // count this cycle
  input  wire logic [TMR_W-1:0] limit_i, // terminal count
  output logic                  done_o   // count reached limit
);
  logic [TMR_W-1:0] cnt_ff;

  // holds at the limit so done stays up until cleared
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      cnt_ff <= '0;
    end else if (en_i && (cnt_ff != limit_i)) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign done_o = (cnt_ff == limit_i) && !clear_i;
endmodule

`default_nettype wire

/* ledfc_top.sv */
// led driver supervision: dimming gate, standby, start-up, fault flag and status level
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module ledfc_top import ledfc_pkg::*; #(
  parameter int unsigned STANDBY_CYCLES = STANDBY_CYC // long low time before standby
) (
  input  wire logic        clk_i,            // 10 MHz clock
  input  wire logic        rst_i,            // sync reset, high
  input  wire logic        wb_cyc_i,         // wishbone cycle
  input  wire logic        wb_stb_i,         // wishbone strobe
  input  wire logic        wb_we_i,          // wishbone write
  input  wire logic [7:0]  wb_adr_i,         // byte address
  input  wire logic [3:0]  wb_sel_i,         // byte enables
  input  wire logic [31:0] wb_dat_i,         // write data
  output logic [31:0]      wb_dat_o,         // read data
  output logic             wb_ack_o,         // wishbone ack
  input  wire logic        pwm_i,            // dimming pin
  input  wire logic        gate_req_i,       // switch request from current loop
  input  wire logic        aux_uv_i,         // aux supply below threshold
  input  wire logic        vin_uv_i,         // input supply below threshold
  input  wire logic        vin_status_ok_i,  // input above status validity bound
  input  wire logic        reg_out_i,        // sense_high_side_voltage out of range
  input  wire logic        oc_i,             // sense above overcurrent limit
  input  wire logic        ot_i,             // junction above max operating
  input  wire logic        thermistor_sense_in_low_i, // thermistor_sense_in below threshold
  input  wire logic        flag_i,           // flag pin level
  output logic             flag_o,           // flag pin drive value
  output logic             flag_oe_n_o,      // flag drive enable, low pulls pin
  output ledfc_level_type  level_code_o,     // status output level code
  output logic             status_valid_o,   // status levels trustworthy
  output logic             gate_o,           // external switch drive
  output logic             bias_en_o,        // internal circuitry powered
  output logic             ref_en_o,         // reference output on
  output logic             current_reduce_o, // thermal current fold-back
  output logic             startup_o,        // start-up interval running
  output logic             irq_o             // level interrupt
);
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  logic pwm_s, gate_req_s, aux_s, vinuv_s, vinok_s, reg_s, oc_s, ot_s, ntc_s, flag_s;
  ledfc_state_type state_ff;
  logic gate_prev_ff;
  logic stby_done, start_done, stall_done;
  logic blank_en_ff;
  logic blank, cond_any;
  ledfc_level_type nxt_level;
  logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff, irq_ev, irq_clr, nxt_irq_stat;
  logic fault_seen_ff;
  logic gate_stall_seen_ff;
  logic wb_req;

  // two flops on every pin input; only the second stage is read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= {flag_i, thermistor_sense_in_low_i, ot_i, oc_i, reg_out_i,
                  vin_status_ok_i, vin_uv_i, aux_uv_i, gate_req_i, pwm_i};
      sync_ff <= meta_ff;
    end
  end
  assign {flag_s, ntc_s, ot_s, oc_s, reg_s, vinok_s, vinuv_s, aux_s, gate_req_s, pwm_s} = sync_ff;

  // low time of the dimming input, restarted by any high sample
  ledfc_timer u_stby_tmr (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (pwm_s || (state_ff == ST_STANDBY)),
    .en_i    (1'b1),
    .limit_i (TMR_W'(STANDBY_CYCLES)),
    .done_o  (stby_done)
  );

  // start-up interval, runs only in the start-up state
  ledfc_timer u_start_tmr (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (state_ff != ST_STARTUP),
    .en_i    (1'b1),
    .limit_i (TMR_W'(STARTUP_CYC)),
    .done_o  (start_done)
  );

  // gate held at one level; dimming-off time is not a stall, so count only while pwm high
  ledfc_timer u_stall_tmr (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i ((gate_o != gate_prev_ff) || !pwm_s || (state_ff == ST_STANDBY)),
    .en_i    (1'b1),
    .limit_i (TMR_W'(STALL_CYC)),
    .done_o  (stall_done)
  );

  // power state: reset starts up; long low enters standby; release restarts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_STARTUP;
    end else begin
      unique case (state_ff)
        ST_STARTUP: begin
          if (stby_done) begin
            state_ff <= ST_STANDBY;
          end else if (start_done) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stby_done) begin
            state_ff <= ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (pwm_s) begin
            state_ff <= ST_STARTUP;
          end
        end
      endcase
    end
  end

  // switch drive: the part stays powered outside standby, pwm only gates the switch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_o       <= 1'b0;
      gate_prev_ff <= 1'b0;
      bias_en_o    <= 1'b1;
      ref_en_o     <= 1'b1;
      startup_o    <= 1'b1;
    end else begin
      gate_o       <= (state_ff != ST_STANDBY) && pwm_s && gate_req_s;
      gate_prev_ff <= gate_o;
      bias_en_o    <= (state_ff != ST_STANDBY);
      ref_en_o     <= 1'b1;
      startup_o    <= (state_ff == ST_STARTUP);
    end
  end

  // thermal fold-back; a pin tied to the reference never trips it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      current_reduce_o <= 1'b0;
    end else begin
      current_reduce_o <= ntc_s && (state_ff != ST_STANDBY);
    end
  end

  // optional start-up blanking; off by default so the inductor charge shows
  assign blank    = blank_en_ff && (state_ff == ST_STARTUP);
  assign cond_any = aux_s || vinuv_s || reg_s || stall_done || ot_s || oc_s;

  // severity priority, highest first
  always_comb begin
    nxt_level = LVL_NORMAL;
    if (state_ff == ST_STANDBY) begin
      nxt_level = LVL_ZERO;
    end else if (blank) begin
      nxt_level = LVL_NORMAL;
    end else if (oc_s) begin
      nxt_level = LVL_SEV4;
    end else if (ot_s) begin
      nxt_level = LVL_SEV3;
    end else if (vinuv_s) begin
      nxt_level = LVL_SEV2_UV;
    end else if (reg_s || stall_done) begin
      nxt_level = LVL_SEV2;
    end
  end

  // registered level code and open-drain flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_code_o   <= LVL_NORMAL;
      flag_o         <= 1'b0;
      flag_oe_n_o    <= 1'b1;
      status_valid_o <= 1'b0;
    end else begin
      level_code_o   <= nxt_level;
      flag_o         <= 1'b0; // open drain only ever pulls low
      flag_oe_n_o    <= !(cond_any && !blank && (state_ff != ST_STANDBY));
      status_valid_o <= vinok_s;
    end
  end

  // events: flag assertion, standby entry, start-up end, stall onset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_seen_ff <= 1'b0;
    end else begin
      fault_seen_ff <= !flag_oe_n_o;
    end
  end
  assign irq_ev[IRQ_FAULT]   = !flag_oe_n_o && !fault_seen_ff;
  assign irq_ev[IRQ_STANDBY] = (state_ff != ST_STANDBY) && stby_done;
  assign irq_ev[IRQ_READY]   = (state_ff == ST_STARTUP) && start_done && !stby_done;
  assign irq_ev[IRQ_STALL]   = stall_done && !gate_stall_seen_ff;

  // remembers the stall so its event fires once per onset, not every cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_stall_seen_ff <= 1'b0;
    end else begin
      gate_stall_seen_ff <= stall_done;
    end
  end

  // wishbone classic slave: ack one cycle after the strobe, dropped the next
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign irq_clr = (wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_IRQ_CLR)) ?
                   wb_dat_i[IRQ_W-1:0] : '0;
  // a new event beats a clear in the same cycle
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
      irq_o       <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_o       <= |(nxt_irq_stat & irq_en_ff);
    end
  end

  // writable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blank_en_ff <= CTRL_BLANK_RST;
      irq_en_ff   <= IRQ_EN_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == OFS_CTRL) begin
        blank_en_ff <= wb_dat_i[CTRL_BLANK_BIT];
      end
      if (wb_adr_i == OFS_IRQ_EN) begin
        irq_en_ff <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // read mux; unmapped and write-only offsets read zero but still ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          OFS_CTRL:     wb_dat_o[CTRL_BLANK_BIT] <= blank_en_ff;
          OFS_STATE: begin
            wb_dat_o[ST_LVL_LSB +: 3] <= level_code_o;
            wb_dat_o[ST_FSM_LSB +: 2] <= state_ff;
            wb_dat_o[ST_FLAG_BIT]     <= flag_s;
            wb_dat_o[ST_VALID_BIT]    <= status_valid_o;
          end
          OFS_IRQ_STAT: wb_dat_o[IRQ_W-1:0] <= irq_stat_ff;
          OFS_IRQ_EN:   wb_dat_o[IRQ_W-1:0] <= irq_en_ff;
          default:      wb_dat_o <= '0;
        endcase
      end
    end
  end

  // checks on the supervision logic
  a_standby_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_STANDBY) |=> !gate_o) else $error("gate driven in standby");
  a_gate_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_RUN && !pwm_s) |=> !gate_o && bias_en_o) else $error("pwm low not gating");
  a_standby_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff != ST_STANDBY && stby_done) |=> state_ff == ST_STANDBY)
    else $error("standby not entered");
  a_standby_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_STANDBY) |=> ##1 (level_code_o == LVL_ZERO || state_ff != ST_STANDBY))
    else $error("status not zero in standby");
  a_standby_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_STANDBY) |=> flag_oe_n_o && ref_en_o) else $error("flag pulled in standby");
  a_restart_seq: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_STANDBY && pwm_s) |=> state_ff == ST_STARTUP ##1 startup_o)
    else $error("no start-up after standby");
  a_flag_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    (cond_any && !blank && state_ff != ST_STANDBY) |=> !flag_oe_n_o && !flag_o)
    else $error("flag not pulled on fault");
  a_normal_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cond_any && state_ff != ST_STANDBY) |=> flag_oe_n_o && level_code_o == LVL_NORMAL)
    else $error("not normal without condition");
  a_aux_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (aux_s && !vinuv_s && !reg_s && !stall_done && !ot_s && !oc_s && !blank
     && state_ff != ST_STANDBY) |=> level_code_o == LVL_NORMAL && !flag_oe_n_o)
    else $error("aux low level wrong");
  a_stall_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (stall_done && !oc_s && !ot_s && !vinuv_s && !blank && state_ff != ST_STANDBY)
    |=> level_code_o == LVL_SEV2) else $error("stall not reported");
  a_oc_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (oc_s && (reg_s || ot_s) && !blank && state_ff != ST_STANDBY)
    |=> level_code_o == LVL_SEV4) else $error("overcurrent lost precedence");
  a_ntc_fold: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ntc_s) && state_ff != ST_STANDBY |=> current_reduce_o)
    else $error("thermal fold-back missing");
  c_standby: cover property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_RUN ##1 state_ff == ST_STANDBY);
  c_ready: cover property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_STARTUP ##1 state_ff == ST_RUN);
  c_sev4: cover property (@(posedge clk_i) disable iff (rst_i) level_code_o == LVL_SEV4);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule

`default_nettype wire

/* ledfc_host_model.sv */
// host controller model: drives the dimming pin and reads the fault flag wire
`timescale 1ns/100ps
`default_nettype none

module ledfc_host_model import ledfc_pkg::*; #(
  parameter int unsigned STBY = STANDBY_CYC // low time that asks for standby
) (
  input  wire logic clk_i,        // system clock
  input  wire logic rst_i,        // sync reset, high
  input  wire logic pwm_cmd_i,    // dimming level wanted by the bench
  input  wire logic flag_drv_i,   // flag drive value
  input  wire logic flag_oe_n_i,  // flag pull-down enable, low active
  output logic      pwm_o,        // dimming pin
  output logic      flag_wire_o,  // resolved flag wire
  output logic      fault_seen_o  // fault noted by the host
);
  logic [17:0] low_cnt_ff;
  logic [17:0] quiet_ff;

  // open-drain wire with pull-up: a released flag reads high
  assign flag_wire_o = flag_oe_n_i ? 1'h1 : flag_drv_i;
  // diagnostics are ignored while a start-up may still be running
  assign fault_seen_o = (quiet_ff == 18'h0) && !flag_wire_o;

  // a long low level is how the host asks for standby; quiet time is
  // slightly longer than the start-up so the charging reports never count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_o      <= pwm_cmd_i;
      low_cnt_ff <= 18'h0;
      quiet_ff   <= 18'(STARTUP_CYC + 4);
    end else begin
      pwm_o      <= pwm_cmd_i;
      low_cnt_ff <= pwm_o ? 18'h0 : low_cnt_ff + 18'h1;
      if (pwm_cmd_i && !pwm_o && (low_cnt_ff > 18'(STBY))) begin
        quiet_ff <= 18'(STARTUP_CYC + 4);
      end else if (quiet_ff != 18'h0) begin
        quiet_ff <= quiet_ff - 18'h1;
      end
    end
  end
endmodule

`default_nettype wire

/* ledfc_top_test.sv */
// self-checking bench for the led supervision block
`timescale 1ns/100ps
`default_nettype none

module ledfc_top_test import ledfc_pkg::*;;
  localparam int unsigned STBY  = 50;
  localparam int          LIMIT = 20000;

  logic            clk_i, rst_i, cyc, stb, we, wb_ack_o, irq_o;
  logic [7:0]      adr;
  logic [3:0]      sel;
  logic [31:0]     wdat, rdat, wb_dat_o;
  logic            pwm_cmd, pwm, flag_w, fault_seen, vin_ok, therm, tog_en, hold;
  logic [4:0]      cond;
  logic            flag_o, flag_oe_n_o, status_valid_o, gate_o, bias_en_o;
  logic            ref_en_o, current_reduce_o, startup_o;
  ledfc_level_type level_code_o;
  logic            tgl = 1'h0;
  logic [5:0]      tick = 6'h0;
  int              n_fail, n_compared;
  int              cyc_cnt = 0;

  // clock at 10 MHz
  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end

  // the current loop keeps switching unless a test holds the gate request
  always @(posedge clk_i) begin
    tick <= tick + 6'h1;
    if (tick == 6'h3F) tgl <= ~tgl;
  end

  ledfc_top #(.STANDBY_CYCLES(STBY)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pwm_i(pwm), .gate_req_i(tog_en ? tgl : hold),
    .aux_uv_i(cond[0]), .vin_uv_i(cond[1]), .vin_status_ok_i(vin_ok),
    .reg_out_i(cond[2]), .oc_i(cond[4]), .ot_i(cond[3]),
    .thermistor_sense_in_low_i(therm), .flag_i(flag_w), .flag_o(flag_o),
    .flag_oe_n_o(flag_oe_n_o), .level_code_o(level_code_o),
    .status_valid_o(status_valid_o), .gate_o(gate_o), .bias_en_o(bias_en_o),
    .ref_en_o(ref_en_o), .current_reduce_o(current_reduce_o),
    .startup_o(startup_o), .irq_o(irq_o));

  ledfc_host_model #(.STBY(STBY)) host_u (
    .clk_i(clk_i), .rst_i(rst_i), .pwm_cmd_i(pwm_cmd), .flag_drv_i(flag_o),
    .flag_oe_n_i(flag_oe_n_o), .pwm_o(pwm), .flag_wire_o(flag_w),
    .fault_seen_o(fault_seen));

  task automatic results();
    $display("compared %0d, wrong %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == LIMIT) begin
      n_fail++;
      results();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // classic single cycle; the answer is taken at the edge that sees ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'h1);
    rdat = wb_dat_o;
    chk("ack_wait", 32'h2, k);
    cyc <= 1'h0;
    stb <= 1'h0;
    we  <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    bus(1'h0, a, 32'h0);
    chk(nm, e, rdat & m);
  endtask

  task automatic t_reset();
    chk("startup", 32'h1, startup_o);
    rd(OFS_STATE, 32'h30, 32'h0, "state");
    rd(OFS_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl");
    rd(OFS_IRQ_EN, 32'hFFFFFFFF, 32'h0, "irq_en");
    rd(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped");
    wt(STARTUP_CYC);
    chk("startup", 32'h0, startup_o);
    rd(OFS_STATE, 32'h30, 32'h10, "state");
    rd(OFS_IRQ_STAT, 32'h4, 32'h4, "irq_stat");
    $display("test reset done");
  endtask

  task automatic sev(input logic [4:0] c, input ledfc_level_type l, input logic oe);
    cond <= c;
    wt(5);
    chk("level", l, level_code_o);
    chk("flag_oe_n", oe, flag_oe_n_o);
    chk("flag", 32'h0, flag_o);
  endtask

  // cond bits: 0 aux, 1 input supply, 2 regulation, 3 temperature, 4 overcurrent
  task automatic t_severity();
    sev(5'h00, LVL_NORMAL, 1'h1);
    sev(5'h01, LVL_NORMAL, 1'h0);
    sev(5'h02, LVL_SEV2_UV, 1'h0);
    sev(5'h04, LVL_SEV2, 1'h0);
    sev(5'h08, LVL_SEV3, 1'h0);
    sev(5'h10, LVL_SEV4, 1'h0);
    sev(5'h14, LVL_SEV4, 1'h0);
    sev(5'h0E, LVL_SEV3, 1'h0);
    sev(5'h07, LVL_SEV2_UV, 1'h0);
    sev(5'h00, LVL_NORMAL, 1'h1);
    vin_ok <= 1'h0;
    cond   <= 5'h01;
    wt(5);
    chk("status_valid", 32'h0, status_valid_o);
    chk("flag_oe_n", 32'h0, flag_oe_n_o);
    rd(OFS_STATE, 32'h80, 32'h0, "state");
    vin_ok <= 1'h1;
    cond   <= 5'h00;
    wt(5);
    chk("status_valid", 32'h1, status_valid_o);
    $display("test severity done");
  endtask

  task automatic t_gate();
    hold   <= 1'h1;
    tog_en <= 1'h0;
    wt(5);
    chk("gate", 32'h1, gate_o);
    pwm_cmd <= 1'h0;
    wt(6);
    chk("gate", 32'h0, gate_o);
    chk("bias_en", 32'h1, bias_en_o);
    pwm_cmd <= 1'h1;
    therm   <= 1'h1;
    wt(6);
    chk("gate", 32'h1, gate_o);
    chk("reduce", 32'h1, current_reduce_o);
    therm <= 1'h0;
    wt(5);
    chk("reduce", 32'h0, current_reduce_o);
    bus(1'h1, OFS_IRQ_CLR, 32'hF);
    // gate is high here, so dropping the request restarts the stall count at a known edge
    hold <= 1'h0;
    wt(STALL_CYC - 10);
    chk("level", LVL_NORMAL, level_code_o);
    wt(30);
    chk("level", LVL_SEV2, level_code_o);
    chk("flag_oe_n", 32'h0, flag_oe_n_o);
    rd(OFS_IRQ_STAT, 32'h8, 32'h8, "irq_stat");
    tog_en <= 1'h1;
    wt(80);
    chk("level", LVL_NORMAL, level_code_o);
    $display("test gate done");
  endtask

  // sticky status, enable mask, write-one clear, read-only status
  task automatic t_irq();
    bus(1'h1, OFS_IRQ_CLR, 32'hF);
    bus(1'h1, OFS_IRQ_EN, 32'h1);
    cond <= 5'h01;
    wt(6);
    chk("irq", 32'h1, irq_o);
    rd(OFS_IRQ_EN, 32'hF, 32'h1, "irq_en");
    bus(1'h1, OFS_IRQ_EN, 32'h0);
    wt(2);
    chk("irq", 32'h0, irq_o);
    cond <= 5'h00;
    wt(5);
    rd(OFS_IRQ_STAT, 32'h1, 32'h1, "irq_stat");
    bus(1'h1, OFS_IRQ_CLR, 32'h1);
    bus(1'h1, OFS_IRQ_STAT, 32'hF);
    rd(OFS_IRQ_STAT, 32'hF, 32'h0, "irq_stat");
    $display("test irq done");
  endtask

  task automatic t_standby();
    cond    <= 5'h01;
    pwm_cmd <= 1'h0;
    wt(STBY - 10);
    chk("bias_en", 32'h1, bias_en_o);
    wt(20);
    chk("bias_en", 32'h0, bias_en_o);
    chk("level", LVL_ZERO, level_code_o);
    chk("flag_oe_n", 32'h1, flag_oe_n_o);
    chk("ref_en", 32'h1, ref_en_o);
    rd(OFS_STATE, 32'h30, 32'h20, "state");
    rd(OFS_IRQ_STAT, 32'h2, 32'h2, "irq_stat");
    pwm_cmd <= 1'h1;
    cond    <= 5'h10;
    wt(6);
    chk("startup", 32'h1, startup_o);
    chk("level", LVL_SEV4, level_code_o);
    chk("fault_seen", 32'h0, fault_seen);
    cond <= 5'h04;
    wt(5);
    chk("level", LVL_SEV2, level_code_o);
    cond <= 5'h01;
    wt(STARTUP_CYC);
    chk("startup", 32'h0, startup_o);
    chk("fault_seen", 32'h1, fault_seen);
    // second standby round trip with start-up blanking switched on
    bus(1'h1, OFS_CTRL, 32'h1);
    rd(OFS_CTRL, 32'h1, 32'h1, "ctrl");
    cond    <= 5'h10;
    pwm_cmd <= 1'h0;
    wt(60);
    chk("level", LVL_ZERO, level_code_o);
    pwm_cmd <= 1'h1;
    wt(6);
    chk("startup", 32'h1, startup_o);
    chk("level", LVL_NORMAL, level_code_o);
    chk("flag_oe_n", 32'h1, flag_oe_n_o);
    wt(STARTUP_CYC + 5);
    chk("level", LVL_SEV4, level_code_o);
    chk("flag_oe_n", 32'h0, flag_oe_n_o);
    $display("test standby done");
  endtask

  initial begin
    rst_i      = 1'h1;
    cyc        = 1'h0;
    stb        = 1'h0;
    we         = 1'h0;
    adr        = 8'h00;
    sel        = 4'h0;
    wdat       = 32'h0;
    pwm_cmd    = 1'h1;
    tog_en     = 1'h1;
    hold       = 1'h0;
    cond       = 5'h00;
    vin_ok     = 1'h1;
    therm      = 1'h0;
    n_fail     = 0;
    n_compared = 0;
    wt(16);
    rst_i <= 1'h0;
    t_reset();
    t_severity();
    t_gate();
    t_irq();
    t_standby();
    results();
  end
endmodule

`default_nettype wire
